// *** core/airflow_map.svh ***
/*
  constants of the airflow sensor target: command bytes, reply codes,
  flow transfer figures, the clock rate and the times behind the cycle counts.
  assumes it is included by bare name from files under core/.
*/
`ifndef AIRFLOW_MAP_SVH
`define AIRFLOW_MAP_SVH

// command bytes written by the controller
`define CMD_READ_SERIAL 8'h01
`define CMD_FORCE_RESTART 8'h02
`define CMD_NVM_CHECK 8'h03

// two-byte status replies, all with 11 in the top bits
`define POSITIVE_ACK_CODE 16'hCCA5
`define UNKNOWN_CMD_CODE 16'hCC99
`define BAD_ARGUMENT_CODE 16'hCC9A
`define EXEC_FAIL_CODE 16'hCC9B
`define NVM_MISMATCH_CODE 16'hCC90
`define BUSY_CODE 16'hCCBB

// flow code = (scale * offset_num + gain_num * ratio) / den, ratio in scale units
`define FLOW_SCALE 18'h04000
`define FLOW_OFFSET_NUM 18'h00001
`define FLOW_GAIN_NUM 18'h00008
`define FLOW_DEN 18'h0000A

// clock rate and the times from which the cycle counts are derived
`define CLK_FREQ_KHZ 40000
`define RESP_TIME_MS 1
`define RESTART_TIME_MS 20

`endif

// *** core/airflow_pkg.sv ***
/*
  types shared by the airflow sensor target and its link engine.
  assumes nothing of its surroundings.
*/
package airflow_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_WRITE, PH_READ} link_phase_t;
  typedef enum logic [1:0] {SER_HI, SER_LO, SER_DONE} serial_step_t;
  typedef enum logic [1:0] {MODE_RUN, MODE_RESTART, MODE_CHECK} mode_t;
  typedef logic [15:0] reply_word_t;
endpackage

// *** core/link_if.sv ***
/*
  carrier between the clock_in side of the target and the scl side.
  assumes each toggle is launched from a flop and held data is stable
  for several cycles of the receiving clock after its toggle.
*/
`timescale 1ns/1ps
interface link_if;
  import airflow_pkg::*;
  reply_word_t reply_word;
  logic word_tgl;
  logic [7:0] cmd_byte;
  logic cmd_extra;
  logic cmd_tgl;
  logic read_done_tgl;
  logic sda_oe;
  modport eng (input reply_word, input word_tgl, output cmd_byte, output cmd_extra,
    output cmd_tgl, output read_done_tgl, output sda_oe);
  modport sys (output reply_word, output word_tgl, input cmd_byte, input cmd_extra,
    input cmd_tgl, input read_done_tgl, input sda_oe);
endinterface

// *** core/link_engine.sv ***
/*
  scl-clocked byte engine of the target: start detect, address match,
  command byte capture and two-byte reply shifting.
  assumes scl_in only toggles inside frames and sda_in is the resolved wire.
*/
`timescale 1ns/1ps
module link_engine #(
  parameter logic [6:0] TARGET_ADDR = 7'h28
) (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic rst_n_in,
  link_if.eng lnk
);
  import airflow_pkg::*;

  link_phase_t phase_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [1:0] byte_idx_q;
  logic start_tgl_q;
  logic start_seen_q;
  logic wt_meta_q;
  logic wt_sync_q;
  logic wt_seen_q;
  reply_word_t shadow_q;
  reply_word_t tx_word_q;
  logic new_start;
  logic addr_hit;

  assign new_start = start_tgl_q != start_seen_q;
  // [R18] fixed target address
  assign addr_hit = rx_sh_q[7:1] == TARGET_ADDR;

  ////////////////////////////////////////////////////////////////////////
  // start condition: sda falls while scl is high
  always_ff @(negedge sda_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_tgl_q <= 1'b0;
    end else if (scl_in) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // reply word crossing: the toggle is synchronised, the word is held
  // stable by the other side, so it is copied once the toggle settles
  always_ff @(posedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wt_meta_q <= 1'b0;
      wt_sync_q <= 1'b0;
      wt_seen_q <= 1'b0;
      shadow_q <= 16'h0000;
    end else begin
      wt_meta_q <= lnk.word_tgl;
      wt_sync_q <= wt_meta_q;
      wt_seen_q <= wt_sync_q;
      if (wt_sync_q != wt_seen_q) begin
        shadow_q <= lnk.reply_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit sampling on the rising edge; count 8 is the acknowledge slot
  always_ff @(posedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= PH_IDLE;
      bit_cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
      byte_idx_q <= 2'h0;
      start_seen_q <= 1'b0;
      tx_word_q <= 16'h0000;
      lnk.cmd_byte <= 8'h00;
      lnk.cmd_extra <= 1'b0;
      lnk.cmd_tgl <= 1'b0;
      lnk.read_done_tgl <= 1'b0;
    end else if (new_start) begin
      start_seen_q <= start_tgl_q;
      phase_q <= PH_ADDR;
      bit_cnt_q <= 4'h1;
      rx_sh_q <= {7'h00, sda_in};
      byte_idx_q <= 2'h0;
    end else if (phase_q != PH_IDLE) begin
      if (bit_cnt_q == 4'h8) begin
        bit_cnt_q <= 4'h0;
        case (phase_q)
          PH_ADDR: begin
            // [R18] other targets ignored
            if (!addr_hit) begin
              phase_q <= PH_IDLE;
            end else if (rx_sh_q[0]) begin
              phase_q <= PH_READ;
              tx_word_q <= shadow_q;
            end else begin
              phase_q <= PH_WRITE;
            end
          end
          PH_WRITE: begin
            // [R14] extra bytes flagged
            lnk.cmd_byte <= rx_sh_q;
            lnk.cmd_extra <= byte_idx_q != 2'h0;
            lnk.cmd_tgl <= ~lnk.cmd_tgl;
            if (byte_idx_q != 2'h3) begin
              byte_idx_q <= byte_idx_q + 2'h1;
            end
          end
          PH_READ: begin
            // [R19] consumed after two bytes
            if (byte_idx_q == 2'h1) begin
              lnk.read_done_tgl <= ~lnk.read_done_tgl;
            end
            if (byte_idx_q != 2'h3) begin
              byte_idx_q <= byte_idx_q + 2'h1;
            end
            if (sda_in) begin
              phase_q <= PH_IDLE;
            end
          end
          default: begin
            phase_q <= PH_IDLE;
          end
        endcase
      end else begin
        rx_sh_q <= {rx_sh_q[6:0], sda_in};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sda is changed only while scl is low; bytes past the second read high
  always_ff @(negedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lnk.sda_oe <= 1'b0;
    end else if (bit_cnt_q == 4'h8) begin
      lnk.sda_oe <= (phase_q == PH_ADDR && addr_hit) || phase_q == PH_WRITE;
    end else if (phase_q == PH_READ && byte_idx_q < 2'h2) begin
      // [R19] high byte first
      lnk.sda_oe <= ~tx_word_q[{~byte_idx_q[0], ~bit_cnt_q[2:0]}];
    end else begin
      lnk.sda_oe <= 1'b0;
    end
  end
endmodule

// *** core/airflow_sensor_target.sv ***
/*
  airflow sensor target: command decode, reply selection, flow refresh,
  nonvolatile check and the crossings to the scl-clocked link engine.
  assumes a 40 MHz clock_in, an open-drain sda resolved outside, and
  flow_ratio_in produced by logic on clock_in in units of 1/16384.
*/
`timescale 1ns/1ps
`include "airflow_map.svh"

// What this block does
// [R1] first read: upper serial bytes
// [R2] second read: lower serial bytes
// [R3] controller spaces the power-up reads
// [R4] afterwards every read returns flow
// [R5] flow refreshed once per response period
// [R6] flow starts 00, status starts 11
// [R7] command write answered on next read
// [R8] serial command replays both serial halves
// [R9] restart command returns to power-up state
// [R10] checksum match answers positive acknowledge
// [R11] checksum mismatch answers mismatch code
// [R12] busy code while checksum runs
// [R13] unknown command byte answers unknown code
// [R14] extra parameter bytes answer bad argument
// [R15] failure during execution answers failure code
// [R16] completed command without data acknowledges
// [R17] flow code from offset and gain
// [R18] answers only its own address
// [R19] reply high byte first, then cleared
module airflow_sensor_target #(
  parameter logic [6:0] TARGET_ADDR = 7'h28,
  parameter logic [31:0] SERIAL_NUMBER = 32'h1357_9BDF, // arbitrary value
  parameter int FLOW_PERIOD_CYC = `RESP_TIME_MS * `CLK_FREQ_KHZ,
  parameter int RESTART_CYC = `RESTART_TIME_MS * `CLK_FREQ_KHZ,
  parameter int NVM_DEPTH = 8,
  parameter logic [15:0] NVM_SEED = 16'h5A00,
  parameter logic [15:0] NVM_STORED_SUM = 16'h0000
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [14:0] flow_ratio_in,
  output logic sda_out_out,
  output logic sda_oe_out,
  output airflow_pkg::mode_t mode_out
);
  import airflow_pkg::*;

  localparam int CHECK_SPAN = NVM_DEPTH + 1;
  // index wide enough for any depth, so a deep store is walked in full
  localparam int IDX_W = (NVM_DEPTH > 1) ? $clog2(NVM_DEPTH) : 1;

  link_if lnk ();

  logic rst_meta_q;
  logic rst_sync_q;
  logic [1:0] ev_meta_q;
  logic [1:0] ev_sync_q;
  logic [1:0] ev_seen_q;
  logic cmd_evt;
  logic read_evt;
  logic [19:0] tick_cnt_q;
  logic flow_tick;
  logic [14:0] ratio_c;
  logic [17:0] flow_num;
  logic [13:0] flow_q;
  logic [15:0] nvm_word [NVM_DEPTH];
  logic [IDX_W-1:0] chk_idx_q;
  logic [15:0] acc_q;
  logic [15:0] acc_next;
  logic chk_last;
  mode_t mode_q;
  logic [19:0] restart_cnt_q;
  logic restart_done;
  serial_step_t ser_q;
  logic pend_q;
  reply_word_t resp_code_q;
  logic start_ser;
  logic start_restart;
  logic start_check;
  logic set_resp;
  reply_word_t set_code;
  reply_word_t reply_d;
  logic sda_out_q;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  link_engine #(
    .TARGET_ADDR(TARGET_ADDR)
  ) u_link (
    .scl_in(scl_in),
    .sda_in(sda_in),
    .rst_n_in(rst_sync_q),
    .lnk(lnk.eng)
  );

  // event crossings from the scl side; bit 1 command, bit 0 read done
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ev_meta_q <= 2'h0;
      ev_sync_q <= 2'h0;
      ev_seen_q <= 2'h0;
    end else begin
      ev_meta_q <= {lnk.cmd_tgl, lnk.read_done_tgl};
      ev_sync_q <= ev_meta_q;
      ev_seen_q <= ev_sync_q;
    end
  end
  // command byte is held for a whole byte time after its toggle, so it
  // is read directly once the toggle has settled
  assign cmd_evt = ev_sync_q[1] ^ ev_seen_q[1];
  assign read_evt = ev_sync_q[0] ^ ev_seen_q[0];

  ////////////////////////////////////////////////////////////////////////
  // [R5] response period tick
  assign flow_tick = tick_cnt_q == 20'h00000;
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tick_cnt_q <= 20'h00000;
    end else if (flow_tick) begin
      tick_cnt_q <= 20'(FLOW_PERIOD_CYC - 1);
    end else begin
      tick_cnt_q <= tick_cnt_q - 20'h00001;
    end
  end

  // [R17] transfer function, ratio clamped to full scale
  assign ratio_c = (flow_ratio_in > 15'h4000) ? 15'h4000 : flow_ratio_in;
  assign flow_num = `FLOW_SCALE * `FLOW_OFFSET_NUM + `FLOW_GAIN_NUM * {3'h0, ratio_c};
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      flow_q <= 14'h0000;
    end else if (flow_tick) begin
      flow_q <= 14'(flow_num / `FLOW_DEN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // nonvolatile contents; a count of seeded words that is a multiple of four folds to zero
  for (genvar gi = 0; gi < NVM_DEPTH; gi++) begin : g_nvm
    assign nvm_word[gi] = NVM_SEED ^ 16'(gi);
  end
  assign acc_next = acc_q ^ nvm_word[chk_idx_q];
  assign chk_last = mode_q == MODE_CHECK && chk_idx_q == IDX_W'(NVM_DEPTH - 1);
  assign restart_done = mode_q == MODE_RESTART && restart_cnt_q == 20'h00000;

  // command decode; a new command while the check runs aborts it
  always_comb begin
    start_ser = 1'b0;
    start_restart = 1'b0;
    start_check = 1'b0;
    set_resp = 1'b0;
    set_code = `POSITIVE_ACK_CODE;
    if (cmd_evt && mode_q != MODE_RESTART) begin
      if (lnk.cmd_extra) begin
        // [R14] bad argument
        set_resp = 1'b1;
        set_code = `BAD_ARGUMENT_CODE;
      end else if (mode_q == MODE_CHECK) begin
        // [R15] check interrupted
        set_resp = 1'b1;
        set_code = `EXEC_FAIL_CODE;
      end else begin
        case (lnk.cmd_byte)
          `CMD_READ_SERIAL: begin
            start_ser = 1'b1;
          end
          `CMD_FORCE_RESTART: begin
            start_restart = 1'b1;
          end
          `CMD_NVM_CHECK: begin
            start_check = 1'b1;
          end
          default: begin
            // [R13] unrecognised byte
            set_resp = 1'b1;
            set_code = `UNKNOWN_CMD_CODE;
          end
        endcase
      end
    end else if (chk_last) begin
      // [R10] [R11] [R16] compare result
      set_resp = 1'b1;
      set_code = (acc_next == NVM_STORED_SUM) ? `POSITIVE_ACK_CODE : `NVM_MISMATCH_CODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operating mode with restart timer and check walk
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mode_q <= MODE_RUN;
      restart_cnt_q <= 20'h00000;
      chk_idx_q <= IDX_W'(0);
      acc_q <= 16'h0000;
    end else begin
      case (mode_q)
        MODE_RUN: begin
          if (start_restart) begin
            // [R9] restart period
            mode_q <= MODE_RESTART;
            restart_cnt_q <= 20'(RESTART_CYC - 1);
          end else if (start_check) begin
            // [R10] one word per cycle
            mode_q <= MODE_CHECK;
            chk_idx_q <= IDX_W'(0);
            acc_q <= 16'h0000;
          end
        end
        MODE_RESTART: begin
          if (restart_done) begin
            mode_q <= MODE_RUN;
          end else begin
            restart_cnt_q <= restart_cnt_q - 20'h00001;
          end
        end
        MODE_CHECK: begin
          if (cmd_evt || chk_last) begin
            mode_q <= MODE_RUN;
          end else begin
            chk_idx_q <= chk_idx_q + IDX_W'(1);
            acc_q <= acc_next;
          end
        end
        default: begin
          mode_q <= MODE_RUN;
        end
      endcase
    end
  end

  // [R1] [R2] [R8] serial sequence; a command wins over a read ending
  // [R3] assumes reads are spaced so each reply settles before the next
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ser_q <= SER_HI;
    end else if (restart_done || start_ser) begin
      ser_q <= SER_HI;
    end else if (read_evt && mode_q == MODE_RUN && !pend_q && !cmd_evt) begin
      case (ser_q)
        SER_HI: begin
          ser_q <= SER_LO;
        end
        SER_LO: begin
          ser_q <= SER_DONE;
        end
        default: begin
          ser_q <= SER_DONE;
        end
      endcase
    end
  end

  // [R7] [R19] pending command reply: any set wins over the read clear
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pend_q <= 1'b0;
      resp_code_q <= `POSITIVE_ACK_CODE;
    end else if (set_resp) begin
      pend_q <= 1'b1;
      resp_code_q <= set_code;
    end else if (start_check) begin
      pend_q <= 1'b1;
      resp_code_q <= `BUSY_CODE;
    end else if (start_ser || start_restart || restart_done) begin
      pend_q <= 1'b0;
    end else if (read_evt && mode_q == MODE_RUN) begin
      pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // [R4] [R6] [R12] reply selection; restart also reads busy
  always_comb begin
    if (mode_q != MODE_RUN) begin
      reply_d = `BUSY_CODE;
    end else if (pend_q) begin
      reply_d = resp_code_q;
    end else begin
      case (ser_q)
        SER_HI: begin
          reply_d = SERIAL_NUMBER[31:16];
        end
        SER_LO: begin
          reply_d = SERIAL_NUMBER[15:0];
        end
        default: begin
          reply_d = {2'b00, flow_q};
        end
      endcase
    end
  end

  // publish the word and toggle only when it changes
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      lnk.reply_word <= 16'h0000;
      lnk.word_tgl <= 1'b0;
    end else if (reply_d != lnk.reply_word) begin
      lnk.reply_word <= reply_d;
      lnk.word_tgl <= ~lnk.word_tgl;
    end
  end

  // open-drain: the level driven is always low, only the enable moves
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  assign sda_out_out = sda_out_q;
  assign sda_oe_out = lnk.sda_oe;
  assign mode_out = mode_q;

  ////////////////////////////////////////////////////////////////////////
  // checks on the clock_in side
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_sync_q);

  serial_high_a: assert property ( // [R1]
    mode_q == MODE_RUN && !pend_q && ser_q == SER_HI |=>
      lnk.reply_word == SERIAL_NUMBER[31:16])
    else $error("serial high half not offered");
  serial_low_a: assert property ( // [R2]
    read_evt && mode_q == MODE_RUN && !pend_q && !cmd_evt && ser_q == SER_HI
      |=> ser_q == SER_LO ##1 lnk.reply_word == SERIAL_NUMBER[15:0])
    else $error("serial low half not offered");
  flow_reply_a: assert property ( // [R4]
    mode_q == MODE_RUN && !pend_q && ser_q == SER_DONE |=>
      lnk.reply_word == {2'b00, $past(flow_q)})
    else $error("flow reply wrong");
  flow_refresh_a: assert property ( // [R5]
    $changed(flow_q) |-> $past(flow_tick))
    else $error("flow changed off the tick");
  status_prefix_a: assert property ( // [R6]
    (pend_q || mode_q != MODE_RUN) |=> lnk.reply_word[15:14] == 2'b11)
    else $error("status reply lacks prefix");
  cmd_pending_a: assert property ( // [R7]
    cmd_evt && mode_q == MODE_RUN && lnk.cmd_byte != `CMD_READ_SERIAL
      && lnk.cmd_byte != `CMD_FORCE_RESTART |=> pend_q)
    else $error("command left no reply");
  serial_cmd_a: assert property ( // [R8]
    cmd_evt && mode_q == MODE_RUN && !lnk.cmd_extra && lnk.cmd_byte == `CMD_READ_SERIAL
      |=> ser_q == SER_HI && !pend_q)
    else $error("serial command not replayed");
  restart_end_a: assert property ( // [R9]
    restart_done |=> mode_q == MODE_RUN && ser_q == SER_HI && !pend_q)
    else $error("restart did not return to power-up");
  check_bound_a: assert property ( // [R10]
    $rose(mode_q == MODE_CHECK) |-> ##[1:CHECK_SPAN] mode_q == MODE_RUN)
    else $error("check ran too long");
  check_result_a: assert property ( // [R11]
    chk_last && !cmd_evt |=> pend_q && resp_code_q == (($past(acc_next) == NVM_STORED_SUM)
      ? `POSITIVE_ACK_CODE : `NVM_MISMATCH_CODE))
    else $error("check result wrong");
  check_busy_a: assert property ( // [R12]
    mode_q == MODE_CHECK |=> lnk.reply_word == `BUSY_CODE)
    else $error("busy not shown during check");
  unknown_cmd_a: assert property ( // [R13]
    cmd_evt && mode_q == MODE_RUN && !lnk.cmd_extra
      && (lnk.cmd_byte == 8'h00 || lnk.cmd_byte > `CMD_NVM_CHECK)
      |=> resp_code_q == `UNKNOWN_CMD_CODE)
    else $error("unknown command not flagged");
  bad_arg_a: assert property ( // [R14]
    cmd_evt && lnk.cmd_extra && mode_q != MODE_RESTART |=> resp_code_q == `BAD_ARGUMENT_CODE)
    else $error("extra byte not flagged");
  exec_fail_a: assert property ( // [R15]
    cmd_evt && !lnk.cmd_extra && mode_q == MODE_CHECK
      |=> mode_q == MODE_RUN && resp_code_q == `EXEC_FAIL_CODE)
    else $error("interrupted check not flagged");
  read_clear_a: assert property ( // [R19]
    read_evt && pend_q && mode_q == MODE_RUN && !cmd_evt |=> !pend_q)
    else $error("reply not cleared after read");

  serial_done_c: cover property (ser_q == SER_LO ##[1:1000] ser_q == SER_DONE);
  check_pass_c: cover property (chk_last && acc_next == NVM_STORED_SUM);
  restart_c: cover property (restart_done);
  unknown_c: cover property (set_resp && set_code == `UNKNOWN_CMD_CODE);
endmodule

// *** verif/i2c_ctl_model.sv ***
/*
  i2c controller model: start, address, command bytes, two-byte reads, stop.
  assumes sda_in is the resolved open-drain wire with a pull-up.
*/
`timescale 1ns/1ps
module i2c_ctl_model #(
  parameter logic [6:0] ADDR = 7'h28
) (
  output logic scl_out,
  output logic pull_out,
  input wire logic sda_in
);
  // scl stands high and sda is released outside frames
  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // one bit: sda moves only while scl is low, sampled at the rise
  task automatic bit_io(input logic b, output logic s);
    #7 pull_out = ~b;
    #8 scl_out = 1'b1;
    s = sda_in;
    #15 scl_out = 1'b0;
  endtask
  // eight bits msb first, then release for the target's ack
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic start(input logic [7:0] a, output logic ack);
    pull_out = 1'b1;
    #15 scl_out = 1'b0;
    send(a, ack);
  endtask
  // the gap lets the next reply word cross before another frame
  task automatic stop();
    #7 pull_out = 1'b1;
    #8 scl_out = 1'b1;
    #15 pull_out = 1'b0;
    #600;
  endtask
  // ack after the first byte, nack after the second
  task automatic read_word(input logic [6:0] adr, output logic ack, output logic [15:0] w);
    logic s;
    start({adr, 1'b1}, ack);
    for (int i = 15; i >= 0; i--) begin
      bit_io(1'b1, w[i]);
      if (i == 8 || i == 0) bit_io(i == 0, s);
    end
    stop();
  endtask
  task automatic write_cmd(input logic [7:0] c, input logic extra);
    logic s;
    start({ADDR, 1'b0}, s);
    send(c, s);
    if (extra) send(8'h00, s);
    stop();
  endtask
endmodule

// *** verif/airflow_sensor_i2c_target_test.sv ***
/*
  self-checking bench of the airflow sensor target with a controller model.
  assumes the short counts below are safe for the design's timing.
*/
`timescale 1ns/1ps
module airflow_sensor_i2c_target_test;
  import airflow_pkg::*;
  localparam int FLOW_CYC = 50;
  localparam int RESTART_C = 200;
  localparam int NVM_D = 256;
  localparam logic [31:0] SERIAL = 32'h2468_ACE0; // arbitrary value
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [14:0] flow_ratio_in = 15'h2000;
  logic scl, pull, sda, sda_out, sda_oe;
  mode_t mode;
  int err_total = 0;
  int checked = 0;
  always #12.5 clock_in = ~clock_in;
  // open-drain wire: anyone pulling wins, else the pull-up
  assign sda = ~(pull | (sda_oe & ~sda_out));
  airflow_sensor_target #(.SERIAL_NUMBER(SERIAL), .FLOW_PERIOD_CYC(FLOW_CYC),
    .RESTART_CYC(RESTART_C), .NVM_DEPTH(NVM_D)) dut_u (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .flow_ratio_in(flow_ratio_in), .sda_out_out(sda_out), .sda_oe_out(sda_oe),
    .mode_out(mode));
  i2c_ctl_model ctl_u (.scl_out(scl), .pull_out(pull), .sda_in(sda));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // a read at our address must be acked and carry the expected word
  task automatic rd(input string name, input logic [15:0] exp);
    logic ack;
    logic [15:0] w;
    ctl_u.read_word(7'h28, ack, w);
    chk({name, " ack"}, {15'h0, ack}, 16'h0000);
    chk(name, w, exp);
  endtask
  // two periods so a refresh surely lands whatever its phase
  task automatic set_flow(input logic [14:0] r);
    @(posedge clock_in) #2 flow_ratio_in = r;
    cycles(2 * FLOW_CYC);
  endtask
  task automatic t_powerup();
    rd("serial hi", SERIAL[31:16]);
    rd("serial lo", SERIAL[15:0]);
    cycles(2 * FLOW_CYC);
    rd("flow half", 16'h2000);
  endtask
  task automatic t_flow();
    set_flow(15'h4000);
    rd("flow full", 16'h3999);
    set_flow(15'h0000);
    rd("flow zero", 16'h0666);
  endtask
  task automatic t_addr();
    logic ack;
    logic [15:0] w;
    ctl_u.read_word(7'h29, ack, w);
    chk("foreign ack", {15'h0, ack}, 16'h0001);
    rd("flow kept", 16'h0666);
  endtask
  task automatic t_cmds();
    ctl_u.write_cmd(8'h01, 1'b0);
    rd("cmd serial hi", SERIAL[31:16]);
    rd("cmd serial lo", SERIAL[15:0]);
    ctl_u.write_cmd(8'h07, 1'b0);
    rd("unknown", 16'hCC99);
    rd("flow after", 16'h0666);
    ctl_u.write_cmd(8'hFF, 1'b1);
    rd("extra byte", 16'hCC9A);
  endtask
  task automatic t_check();
    ctl_u.write_cmd(8'h03, 1'b0);
    chk("mode check", {14'h0, mode}, {14'h0, MODE_CHECK});
    rd("busy", 16'hCCBB);
    cycles(NVM_D + 10);
    rd("sum ok", 16'hCCA5);
    ctl_u.write_cmd(8'h03, 1'b0);
    ctl_u.write_cmd(8'h01, 1'b0);
    rd("abort", 16'hCC9B);
  endtask
  task automatic t_restart();
    ctl_u.write_cmd(8'h02, 1'b0);
    chk("mode restart", {14'h0, mode}, {14'h0, MODE_RESTART});
    rd("restart busy", 16'hCCBB);
    cycles(RESTART_C);
    rd("restart hi", SERIAL[31:16]);
    rd("restart lo", SERIAL[15:0]);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // reset for three cycles, idle gap, then the scenarios in turn
  initial begin
    cycles(3);
    #2 rst_n_in = 1'b1;
    cycles(20);
    t_powerup();
    t_flow();
    t_addr();
    t_cmds();
    t_check();
    t_restart();
    print_verdict();
  end
  // the scenarios need well under a tenth of this span
  initial begin
    #2000000;
    err_total++;
    print_verdict();
  end
endmodule
